/* File: rtl/tws_pkg.sv */
// Shared constants for the two-wire memory slave with temperature table
package tws_pkg;
    localparam int CLK_NS = 5;
    localparam int CONV_MS = 10;
    localparam int CONV_CYC = CONV_MS * 1000000 / CLK_NS;
    localparam int WR_MS = 10;
    localparam int WR_CYC = WR_MS * 1000000 / CLK_NS;
    localparam logic [3:0] DEV_TYPE = 4'h5; // Arbitrary type code
    localparam logic [7:0] A_TSEL = 8'hE0;
    localparam logic [7:0] A_CFG = 8'hE1;
    localparam logic [2:0] SRAM_TAG = 3'h7;
    localparam logic [4:0] I_TSEL = 5'h00;
    localparam logic [4:0] I_CFG = 5'h01;
    localparam logic [4:0] I_TMSB = 5'h02;
    localparam logic [4:0] I_TLSB = 5'h03;
    localparam logic [4:0] I_PTR = 5'h04;
    localparam logic [4:0] I_ASEL = 5'h07;
    localparam logic [4:0] I_RES0 = 5'h10;
    localparam logic [4:0] I_RES1 = 5'h11;
    localparam logic [7:0] TSEL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h03;
    localparam logic [7:0] ASEL_RST = 8'h01;
    localparam int CFG_AEN = 0;
    localparam int CFG_TEN = 1;
    localparam int CFG_TAU = 2;
    localparam int ASEL_ENB = 0;
    localparam int USER_LEN = 128;
    localparam int LUT_LEN = 72;
    localparam int NV_LEN = USER_LEN + 2 * LUT_LEN;
    localparam logic [8:0] LUT1_BASE = 9'h080;
    localparam logic [8:0] LUT2_BASE = 9'h0C8;
    localparam logic [7:0] NV_FILL = 8'hFF;
    localparam int TEMP_OFS = 640;
    localparam int STEP16 = 32;
    localparam int HYS16 = 16;
    localparam int IDX_MAX = 71;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_RX = 6'h04,
        ST_ACK = 6'h08,
        ST_TX = 6'h10,
        ST_MACK = 6'h20
    } tws_state_t;
endpackage

/* File: rtl/tws_sync.sv */
// Two-stage level synchroniser, one bit per lane
`timescale 1ns/1ps
module tws_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
    assign q = q_reg;
endmodule

/* File: rtl/tws_tempctl.sv */
// Conversion pacing, table index with hysteresis, and write-cycle timer
`timescale 1ns/1ps
module tws_tempctl import tws_pkg::*; #(
    parameter int CONV_N = CONV_CYC,
    parameter int WR_N = WR_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [12:0] temp_in,
    input wire logic bus_act,
    input wire logic commit_tgl,
    output logic [12:0] temp_val,
    output logic [6:0] idx_val,
    output logic upd_tgl,
    output logic wr_busy
);
    logic [1:0] s;
    logic [21:0] conv_reg, conv_next, wr_reg, wr_next;
    logic [12:0] temp_reg, temp_next;
    logic [6:0] idx_reg, idx_next;
    logic upd_reg, upd_next, cm_reg, first_reg, first_next;
    int t16, cand, cur;

    tws_sync #(.W(2)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({bus_act, commit_tgl}),
        .q(s)
    );

    always_comb begin
        t16 = $signed(temp_in) + TEMP_OFS;
        cand = (t16 < 0) ? 0 : (t16 >>> 5);
        cur = int'(idx_reg);
        if (cand > IDX_MAX) begin
            cand = IDX_MAX;
        end
        conv_next = conv_reg;
        temp_next = temp_reg;
        idx_next = idx_reg;
        upd_next = upd_reg;
        first_next = first_reg;
        wr_next = wr_reg;
        if (conv_reg != 22'h0) begin
            conv_next = conv_reg - 22'h1;
        end else if (!s[1]) begin
            conv_next = 22'(CONV_N - 1);
            temp_next = temp_in;
            upd_next = !upd_reg;
            first_next = 1'b0;
            // Only move a step once past the boundary by a full degree
            if (first_reg || t16 >= STEP16 * cur + STEP16 + HYS16 || t16 < STEP16 * cur - HYS16) begin
                idx_next = 7'(cand);
            end
        end
        if (s[0] != cm_reg) begin
            wr_next = 22'(WR_N);
        end else if (wr_reg != 22'h0) begin
            wr_next = wr_reg - 22'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_reg <= 22'h0;
            temp_reg <= 13'h0;
            idx_reg <= 7'h0;
            upd_reg <= 1'b0;
            first_reg <= 1'b1;
            wr_reg <= 22'h0;
            cm_reg <= 1'b0;
        end else begin
            conv_reg <= conv_next;
            temp_reg <= temp_next;
            idx_reg <= idx_next;
            upd_reg <= upd_next;
            first_reg <= first_next;
            wr_reg <= wr_next;
            cm_reg <= s[0];
        end
    end

    assign temp_val = temp_reg;
    assign idx_val = idx_reg;
    assign upd_tgl = upd_reg;
    assign wr_busy = wr_reg != 22'h0;
endmodule

/* File: rtl/tws_slave.sv */
// Two-wire memory slave: serial engine, memories and table loading
`timescale 1ns/1ps
module tws_slave import tws_pkg::*; #(
    parameter logic [3:0] TYPE_CODE = DEV_TYPE, // Arbitrary value
    parameter int CONV_N = CONV_CYC,
    parameter int WR_N = WR_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_bit_2,
    input wire logic select_bit_1,
    input wire logic select_bit_0,
    input wire logic wp,
    input wire logic [12:0] temp_in,
    output logic [7:0] res0_setting,
    output logic [7:0] res1_setting,
    output logic low_power
);
    logic [7:0] s;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic busy_s;
    logic upd_s;
    logic [2:0] pins_s;
    logic [2:0] sel;
    logic scl_p_reg;
    logic sda_p_reg;
    logic upd_p_reg;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic upd;
    logic wbusy;
    logic [12:0] temp_val;
    logic [6:0] idx_val;
    logic [6:0] idx_eff;
    logic upd_tgl;
    logic wr_busy;
    tws_state_t st_reg;
    tws_state_t st_next;
    logic [3:0] bitc_reg;
    logic [3:0] bitc_next;
    logic [7:0] shf_reg;
    logic [7:0] shf_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic oe_reg;
    logic oe_next;
    logic rw_reg;
    logic rw_next;
    logic first_reg;
    logic first_next;
    logic mack_reg;
    logic mack_next;
    logic pend_reg;
    logic pend_next;
    logic cm_reg;
    logic cm_next;
    logic commit;
    logic wr_byte;
    logic [7:0] rd_byte;
    logic [7:0] nv [0:NV_LEN-1];
    logic [7:0] sram [0:31];
    logic [7:0] pbuf [0:7];

    tws_sync #(.W(8)) u_pin_sync (
        .clk(link_clk),
        .rst_n(rst_n),
        .d({scl_in, sda_in, wp, select_bit_2, select_bit_1, select_bit_0, wr_busy, upd_tgl}),
        .q(s)
    );
    assign {scl_s, sda_s, wp_s, pins_s, busy_s, upd_s} = s;

    tws_tempctl #(.CONV_N(CONV_N), .WR_N(WR_N)) u_temp (
        .clk(clk),
        .rst_n(rst_n),
        .temp_in(temp_in),
        .bus_act(st_reg != ST_IDLE),
        .commit_tgl(cm_reg),
        .temp_val(temp_val),
        .idx_val(idx_val),
        .upd_tgl(upd_tgl),
        .wr_busy(wr_busy)
    );

    // Map a bus address onto the nonvolatile array; bit 9 flags a hit
    function automatic logic [9:0] nv_map(input logic [7:0] a, input logic [7:0] tsel);
        logic [9:0] r;
        r = 10'h0;
        if (!a[7]) begin
            if (tsel == 8'h00) begin
                r = {1'b1, 2'b00, a[6:0]};
            end else if (tsel == 8'h01 && a < 8'(LUT_LEN)) begin
                r = {1'b1, LUT1_BASE + {1'b0, a}};
            end else if (tsel == 8'h02 && a < 8'(LUT_LEN)) begin
                r = {1'b1, LUT2_BASE + {1'b0, a}};
            end
        end
        return r;
    endfunction

    assign scl_rise = scl_s && !scl_p_reg;
    assign scl_fall = !scl_s && scl_p_reg;
    assign start = scl_s && scl_p_reg && sda_p_reg && !sda_s;
    assign stop = scl_s && scl_p_reg && !sda_p_reg && sda_s;
    assign upd = upd_s != upd_p_reg;
    // Local flag covers the sync delay before the timer's busy arrives
    assign wbusy = busy_s || pend_reg;
    assign sel = sram[I_ASEL][ASEL_ENB] ? pins_s : sram[I_ASEL][3:1];
    assign idx_eff = sram[I_CFG][CFG_AEN] ? idx_val : sram[I_PTR][6:0];

    always_comb begin
        logic [9:0] m;
        m = nv_map(ptr_reg, sram[I_TSEL]);
        if (ptr_reg[7:5] == SRAM_TAG) begin
            rd_byte = sram[ptr_reg[4:0]];
        end else if (m[9]) begin
            rd_byte = nv[m[8:0]];
        end else begin
            rd_byte = NV_FILL;
        end
    end

    always_comb begin
        st_next = st_reg;
        bitc_next = bitc_reg;
        shf_next = shf_reg;
        oe_next = oe_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        ptr_next = ptr_reg;
        mask_next = mask_reg;
        mack_next = mack_reg;
        pend_next = busy_s ? 1'b0 : pend_reg;
        cm_next = cm_reg;
        commit = 1'b0;
        wr_byte = 1'b0;
        if (start) begin
            st_next = ST_ADDR;
            bitc_next = 4'h0;
            oe_next = 1'b0;
            mask_next = 8'h00;
        end else if (stop) begin
            st_next = ST_IDLE;
            oe_next = 1'b0;
            mask_next = 8'h00;
            if (mask_reg != 8'h00 && !wp_s) begin
                commit = 1'b1;
                cm_next = !cm_reg;
                pend_next = 1'b1;
            end
        end else begin
            case (st_reg)
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        shf_next = {shf_reg[6:0], sda_s};
                        bitc_next = bitc_reg + 4'h1;
                    end else if (scl_fall && bitc_reg == 4'h8) begin
                        bitc_next = 4'h0;
                        if (st_reg == ST_ADDR) begin
                            if (shf_reg[7:4] == TYPE_CODE && shf_reg[3:1] == sel && !wbusy) begin
                                st_next = ST_ACK;
                                oe_next = 1'b1;
                                rw_next = shf_reg[0];
                                first_next = 1'b1;
                            end else begin
                                st_next = ST_IDLE;
                            end
                        end else begin
                            st_next = ST_ACK;
                            oe_next = 1'b1;
                            if (first_reg) begin
                                ptr_next = shf_reg;
                                first_next = 1'b0;
                            end else begin
                                wr_byte = 1'b1;
                                mask_next[ptr_reg[2:0]] = 1'b1;
                                ptr_next = {ptr_reg[7:3], ptr_reg[2:0] + 3'h1};
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bitc_next = 4'h0;
                        if (rw_reg) begin
                            st_next = ST_TX;
                            shf_next = rd_byte;
                            oe_next = !rd_byte[7];
                            ptr_next = ptr_reg + 8'h01;
                        end else begin
                            st_next = ST_RX;
                            oe_next = 1'b0;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bitc_next = bitc_reg + 4'h1;
                        shf_next = {shf_reg[6:0], 1'b1};
                        if (bitc_reg == 4'h7) begin
                            st_next = ST_MACK;
                            oe_next = 1'b0;
                        end else begin
                            oe_next = !shf_reg[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_next = !sda_s;
                    end else if (scl_fall) begin
                        if (mack_reg) begin
                            st_next = ST_TX;
                            bitc_next = 4'h0;
                            shf_next = rd_byte;
                            oe_next = !rd_byte[7];
                            ptr_next = ptr_reg + 8'h01;
                        end else begin
                            st_next = ST_IDLE;
                            oe_next = 1'b0;
                        end
                    end
                end
                default: begin
                    st_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            bitc_reg <= 4'h0;
            shf_reg <= 8'h00;
            oe_reg <= 1'b0;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            ptr_reg <= 8'h00;
            mask_reg <= 8'h00;
            mack_reg <= 1'b0;
            pend_reg <= 1'b0;
            cm_reg <= 1'b0;
            scl_p_reg <= 1'b1;
            sda_p_reg <= 1'b1;
            upd_p_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            bitc_reg <= bitc_next;
            shf_reg <= shf_next;
            oe_reg <= oe_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            ptr_reg <= ptr_next;
            mask_reg <= mask_next;
            mack_reg <= mack_next;
            pend_reg <= pend_next;
            cm_reg <= cm_next;
            scl_p_reg <= scl_s;
            sda_p_reg <= sda_s;
            upd_p_reg <= upd_s;
        end
    end

    // Memories; later writes win so a table update overrides a commit
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NV_LEN; i++) begin
                nv[i] <= NV_FILL;
            end
            for (int i = 0; i < 32; i++) begin
                sram[i] <= 8'h00;
            end
            for (int i = 0; i < 8; i++) begin
                pbuf[i] <= 8'h00;
            end
            sram[I_TSEL] <= TSEL_RST;
            sram[I_CFG] <= CFG_RST;
            sram[I_ASEL] <= ASEL_RST;
        end else begin
            if (wr_byte) begin
                pbuf[ptr_reg[2:0]] <= shf_reg;
            end
            if (commit) begin
                for (int i = 0; i < 8; i++) begin
                    if (mask_reg[i]) begin
                        if (ptr_reg[7:5] == SRAM_TAG) begin
                            sram[{ptr_reg[4:3], 3'(i)}] <= pbuf[i];
                        end else if (nv_map({ptr_reg[7:3], 3'(i)}, sram[I_TSEL]) >= 10'h200) begin
                            nv[9'(nv_map({ptr_reg[7:3], 3'(i)}, sram[I_TSEL]))] <= pbuf[i];
                        end
                    end
                end
            end
            if (upd) begin
                sram[I_TMSB] <= temp_val[12:5];
                sram[I_TLSB] <= {temp_val[4:0], 3'h0};
                sram[I_CFG][CFG_TAU] <= 1'b1;
                if (sram[I_CFG][CFG_AEN]) begin
                    sram[I_PTR] <= {1'b0, idx_val};
                end
                if (sram[I_CFG][CFG_TEN]) begin
                    sram[I_RES0] <= nv[LUT1_BASE + {2'b00, idx_eff}];
                    sram[I_RES1] <= nv[LUT2_BASE + {2'b00, idx_eff}];
                end
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = oe_reg;
    assign res0_setting = sram[I_RES0];
    assign res1_setting = sram[I_RES1];
    assign low_power = (st_reg == ST_IDLE) && !wbusy;
endmodule

/* File: tb/tws_slave_monitor.sv */
// Bound checker for the two-wire slave pins
`timescale 1ns/1ps
module tws_slave_monitor import tws_pkg::*; #(
    parameter int WR_N = WR_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic low_power
);
    int idle_cnt_reg;
    int idle_cnt_next;
    // Busy on an idle bus only while a write cycle runs
    always_comb begin
        idle_cnt_next = (!low_power && scl_in && sda_in) ? idle_cnt_reg + 1 : 0;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_reg <= 0;
        end else begin
            idle_cnt_reg <= idle_cnt_next;
        end
    end
    a_sda_out_low: assert property (@(posedge link_clk) disable iff (!rst_n)
        sda_out == 1'h0) else $error("data output not low");
    a_oe_stable_high: assert property (@(posedge link_clk) disable iff (!rst_n)
        (scl_in && $past(scl_in)) |-> $stable(sda_oe)) else $error("data moved with clock high");
    a_oe_edge_timing: assert property (@(posedge link_clk) disable iff (!rst_n)
        $changed(sda_oe) |-> !scl_in && ($past(scl_in, 4) || $past(scl_in, 5) || $past(scl_in, 6)))
        else $error("data change not tied to clock fall");
    a_ack_held: assert property (@(posedge link_clk) disable iff (!rst_n)
        $rose(sda_oe) |-> sda_oe [*4]) else $error("driven bit too short");
    a_drive_not_standby: assert property (@(posedge link_clk) disable iff (!rst_n)
        sda_oe |-> !low_power) else $error("driving while in standby");
    a_start_wakes: assert property (@(posedge link_clk) disable iff (!rst_n)
        (scl_in && $fell(sda_in)) |-> ##[1:6] !low_power) else $error("start not seen");
    a_stop_quiet: assert property (@(posedge link_clk) disable iff (!rst_n)
        (scl_in && $rose(sda_in)) |-> ##1 !sda_oe [*6]) else $error("driving after stop");
    a_write_bounded: assert property (@(posedge clk) disable iff (!rst_n)
        idle_cnt_reg <= WR_N + 64) else $error("write cycle too long");
endmodule
bind tws_slave tws_slave_monitor #(.WR_N(WR_N)) i_mon (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .low_power(low_power));

/* File: tb/tws_master.sv */
// Behavioural two-wire bus master, clock still outside frames
`timescale 1ns/1ps
module tws_master (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_pull
);
    initial begin
        scl = 1'h1;
        sda_pull = 1'h0;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Data moves only with clock low, away from the fall
    task automatic bit_io(input logic b, output logic r);
        w(8);
        sda_pull = !b;
        w(22);
        scl = 1'h1;
        w(30);
        r = sda_wire;
        scl = 1'h0;
    endtask
    task automatic start();
        w(8);
        sda_pull = 1'h0;
        w(22);
        scl = 1'h1;
        w(30);
        sda_pull = 1'h1;
        w(30);
        scl = 1'h0;
    endtask
    task automatic stop();
        w(8);
        sda_pull = 1'h1;
        w(22);
        scl = 1'h1;
        w(30);
        sda_pull = 1'h0;
        w(30);
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'h1, r);
        ack = !r;
    endtask
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'h1, r);
            d[i] = r;
        end
        bit_io(!mack, r);
    endtask
    task automatic recover();
        logic r;
        scl = 1'h0;
        repeat (9) bit_io(1'h1, r);
    endtask
endmodule

/* File: tb/tws_slave_tb.sv */
// Self-checking bench for the two-wire memory slave
`timescale 1ns/1ps
module tws_slave_tb import tws_pkg::*;;
    logic clk, link_clk, rst_n, wp, scl, m_pull, sda_out, sda_oe, low_power;
    logic [12:0] temp_in;
    logic [7:0] res0, res1;
    int miscompares = 0;
    int total_checks = 0;
    int cycles = 0;
    wire sda_wire = !(sda_oe && !sda_out) && !m_pull;
    tws_slave #(.CONV_N(200), .WR_N(2000)) i_dut (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .select_bit_2(1'h1),
        .select_bit_1(1'h0), .select_bit_0(1'h1), .wp(wp), .temp_in(temp_in), .res0_setting(res0),
        .res1_setting(res1), .low_power(low_power));
    tws_master i_mst (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_pull(m_pull));
    initial begin
        clk = 1'h0;
        forever #2.5 clk = !clk;
    end
    // Unrelated phase to the system clock
    initial begin
        link_clk = 1'h0;
        #7.3;
        forever #15 link_clk = !link_clk;
    end
    task automatic close_out();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic idle_wait();
        int n = 0;
        while (low_power !== 1'h1 && n < 20000) begin
            @(negedge clk);
            n++;
        end
        chk1(low_power, 1'h1);
    endtask
    task automatic dev(input logic rw, input logic ack_exp);
        logic a;
        i_mst.start();
        i_mst.wbyte({DEV_TYPE, 3'h5, rw}, a);
        chk1(a, ack_exp);
    endtask
    task automatic seta(input logic [7:0] a);
        logic k;
        dev(1'h0, 1'h1);
        i_mst.wbyte(a, k);
        chk1(k, 1'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic k;
        seta(a);
        i_mst.wbyte(d, k);
        chk1(k, 1'h1);
        i_mst.stop();
        idle_wait();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        seta(a);
        dev(1'h1, 1'h1);
        i_mst.rbyte(1'h0, d);
        i_mst.stop();
        chk8(d, exp);
    endtask
    task automatic t_select();
        logic k;
        i_mst.start();
        i_mst.wbyte({DEV_TYPE, 3'h2, 1'h1}, k);
        chk1(k, 1'h0);
        i_mst.start();
        i_mst.wbyte({~DEV_TYPE, 3'h5, 1'h1}, k);
        chk1(k, 1'h0);
        i_mst.stop();
        idle_wait();
        wr(8'hE7, 8'h06);
        dev(1'h0, 1'h0);
        i_mst.start();
        i_mst.wbyte({DEV_TYPE, 3'h3, 1'h0}, k);
        chk1(k, 1'h1);
        i_mst.wbyte(8'hE7, k);
        i_mst.wbyte(8'h01, k);
        i_mst.stop();
        idle_wait();
    endtask
    task automatic t_page();
        logic k;
        logic [7:0] d;
        seta(8'h00);
        for (int i = 0; i < 8; i++) begin
            i_mst.wbyte(8'h10 + 8'(i), k);
            chk1(k, 1'h1);
        end
        i_mst.stop();
        k = 1'h0;
        for (int t = 0; t < 8 && k !== 1'h1; t++) begin
            if (t > 0)
                i_mst.stop();
            i_mst.start();
            i_mst.wbyte({DEV_TYPE, 3'h5, 1'h0}, k);
            if (t == 0)
                chk1(k, 1'h0);
        end
        chk1(k, 1'h1);
        i_mst.wbyte(8'h00, k);
        dev(1'h1, 1'h1);
        for (int i = 0; i < 8; i++) begin
            i_mst.rbyte(i < 7, d);
            chk8(d, 8'h10 + 8'(i));
        end
        i_mst.stop();
        dev(1'h1, 1'h1);
        i_mst.rbyte(1'h0, d);
        i_mst.stop();
        chk8(d, 8'hFF);
    endtask
    task automatic t_wrap();
        logic [7:0] d;
        seta(8'hFF);
        dev(1'h1, 1'h1);
        i_mst.rbyte(1'h1, d);
        chk8(d, 8'h00);
        i_mst.rbyte(1'h0, d);
        i_mst.stop();
        chk8(d, 8'h10);
    endtask
    task automatic t_abort();
        logic k;
        logic [7:0] d;
        seta(8'h20);
        i_mst.wbyte(8'h55, k);
        dev(1'h1, 1'h1);
        i_mst.rbyte(1'h0, d);
        i_mst.stop();
        chk8(d, 8'hFF);
        repeat (60) @(negedge clk);
        chk1(low_power, 1'h1);
        rd(8'h20, 8'hFF);
    endtask
    task automatic t_wp();
        wp = 1'h1;
        wr(8'h30, 8'hAA);
        wp = 1'h0;
        rd(8'h30, 8'hFF);
    endtask
    task automatic t_temp();
        rd(8'hE2, 8'h0C);
        rd(8'hE3, 8'h88);
        rd(8'hE4, 8'h20);
        chk8(res0, 8'hFF);
        chk8(res1, 8'hFF);
        temp_in = 13'h01A8;
        repeat (600) @(negedge clk);
        rd(8'hE4, 8'h20);
        temp_in = 13'h01B0;
        repeat (600) @(negedge clk);
        rd(8'hE4, 8'h21);
        wr(8'hE0, 8'h01);
        wr(8'h47, 8'h3C);
        wr(8'hE0, 8'h02);
        wr(8'h47, 8'hC3);
        temp_in = 13'h06E0;
        repeat (600) @(negedge clk);
        rd(8'hE4, 8'h47);
        chk8(res0, 8'h3C);
        chk8(res1, 8'hC3);
        wr(8'hE1, 8'h00);
        wr(8'hF0, 8'h5A);
        repeat (40) @(negedge clk);
        chk8(res0, 8'h5A);
    endtask
    initial begin
        rst_n = 1'h0;
        wp = 1'h0;
        temp_in = 13'h0191;
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        repeat (20) @(negedge clk);
        i_mst.recover();
        t_select();
        t_page();
        t_wrap();
        t_abort();
        t_wp();
        t_temp();
        close_out();
    end
endmodule
